// >>> rtl/host_port_map.svh
`ifndef HOST_PORT_MAP_SVH
`define HOST_PORT_MAP_SVH

// ****************************************
// timing at the 100 MHz mclk
// ****************************************
`define MCLK_PERIOD_PS   10000
`define FLAG_UPD_NS      15
`define READ_VALID_NS    13
`define READ_HOLD_NS     3

// ****************************************
// synchronised pin vector layout
// ****************************************
`define PIN_W            15
`define PIN_SEL_N        14
`define PIN_RD_N         13
`define PIN_WR_N         12
`define PIN_DS           11
`define PIN_DIR          10
`define PIN_STAT         9
`define PIN_HALF         8
`define PIN_DATA_HI      7
`define PIN_DATA_LO      0
`define PIN_IDLE         15'h7400

// ****************************************
// reset values and status byte layout
// ****************************************
`define OBE_RST          1'b1
`define IBF_RST          1'b0
`define STAT_OBE_BIT     0
`define STAT_IBF_BIT     1
`define BYTE_RST         8'h00
`define WORD_RST         16'h0000

`endif

// >>> rtl/host_port_pkg.sv
`default_nettype none

package host_port_pkg;

    typedef enum logic [3:0] {
        st_idle  = 4'b0001,
        st_read  = 4'b0010,
        st_write = 4'b0100,
        st_hold  = 4'b1000
    } xfer_state_e;

endpackage

`default_nettype wire

// >>> rtl/pin_sync.sv
`default_nettype none

module pin_sync #(
    parameter int           W       = 15,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         mclk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] q
);

    generate
        if (W < 1) begin : g_bad
            $error("pin_sync width must be at least one");
        end
    endgenerate

    logic [W-1:0] ff1_r;
    logic [W-1:0] ff2_r;
    logic [W-1:0] ff3_r;

    // ****************************************
    // three stages, change accepted when two agree
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic q_r;
            logic q_nxt;
            always_comb begin
                q_nxt = (ff2_r[i] == ff3_r[i]) ? ff3_r[i] : q_r;
            end
            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    ff1_r[i] <= RST_VAL[i];
                    ff2_r[i] <= RST_VAL[i];
                    ff3_r[i] <= RST_VAL[i];
                    q_r      <= RST_VAL[i];
                end else begin
                    ff1_r[i] <= pin[i];
                    ff2_r[i] <= ff1_r[i];
                    ff3_r[i] <= ff2_r[i];
                    q_r      <= q_nxt;
                end
            end
            assign q[i] = q_r;
        end
    endgenerate

endmodule // pin_sync

`default_nettype wire

// >>> rtl/parallel_host_port.sv
`include "host_port_map.svh"
`default_nettype none

module parallel_host_port #(
    parameter int BYTE_W = 8,
    parameter int WORD_W = 16
) (
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              host_select_n,
    input  wire logic              host_read_strobe_n,
    input  wire logic              host_write_strobe_n,
    input  wire logic              host_data_strobe,
    input  wire logic              host_direction_line,
    input  wire logic              status_select,
    input  wire logic              byte_half_select,
    input  wire logic [BYTE_W-1:0] host_byte_bus_in,
    output logic      [BYTE_W-1:0] host_byte_bus_out,
    output logic                   host_byte_bus_oe,
    output logic                   out_buffer_empty_flag,
    output logic                   in_buffer_full_flag,
    input  wire logic              single_strobe_mode,
    input  wire logic              data_strobe_active_high,
    input  wire logic              word_mode,
    input  wire logic              obe_invert,
    input  wire logic              ibf_invert,
    input  wire logic [WORD_W-1:0] out_word,
    input  wire logic              out_word_load,
    output logic                   out_word_pending,
    output logic      [WORD_W-1:0] in_word,
    output logic                   in_word_ready,
    input  wire logic              in_word_take
);

    localparam int FLAG_UPD_CYC = (`FLAG_UPD_NS * 1000 / `MCLK_PERIOD_PS)
                                  < 1 ? 1 :
                                  (`FLAG_UPD_NS * 1000 / `MCLK_PERIOD_PS);
    localparam int HOLD_CYC = (`READ_HOLD_NS * 1000 + `MCLK_PERIOD_PS - 1)
                              / `MCLK_PERIOD_PS;

    generate
        if (BYTE_W != 8 || WORD_W != 2 * BYTE_W) begin : g_bad
            $error("port needs an 8-bit bus and a word of two bytes");
        end
        if (FLAG_UPD_CYC != 1 || HOLD_CYC != 1) begin : g_bad_time
            $error("flag and hold timing assume one cycle at this clock");
        end
    endgenerate

    // ****************************************
    // pin synchroniser
    // ****************************************
    logic [`PIN_W-1:0] pin_s;

    pin_sync #(
        .W       (`PIN_W),
        .RST_VAL (`PIN_IDLE)
    ) u_pin_sync (
        .mclk  (mclk),
        .rst_b (rst_b),
        .pin   ({host_select_n, host_read_strobe_n, host_write_strobe_n,
                 host_data_strobe, host_direction_line, status_select,
                 byte_half_select, host_byte_bus_in}),
        .q     (pin_s)
    );

    logic              sel_act;
    logic              rd_act;
    logic              wr_act;
    logic              ds_act;
    logic              dir_rd;
    logic              stat_s;
    logic              half_s;
    logic [BYTE_W-1:0] data_s;
    logic              rd_frame;
    logic              wr_frame;

    always_comb begin
        sel_act = !pin_s[`PIN_SEL_N];
        rd_act  = !pin_s[`PIN_RD_N];
        wr_act  = !pin_s[`PIN_WR_N];
        ds_act  = pin_s[`PIN_DS] == data_strobe_active_high;
        dir_rd  = pin_s[`PIN_DIR];
        stat_s  = pin_s[`PIN_STAT];
        half_s  = pin_s[`PIN_HALF];
        data_s  = pin_s[`PIN_DATA_HI:`PIN_DATA_LO];
        if (single_strobe_mode) begin
            rd_frame = sel_act && ds_act;
            wr_frame = sel_act && ds_act;
        end else begin
            rd_frame = sel_act && rd_act;
            wr_frame = sel_act && wr_act;
        end
    end

    // ****************************************
    // transaction state and buffers
    // ****************************************
    host_port_pkg::xfer_state_e state_r;
    host_port_pkg::xfer_state_e state_nxt;
    logic              stat_r;
    logic              stat_nxt;
    logic              half_r;
    logic              half_nxt;
    logic [BYTE_W-1:0] rdata_r;
    logic [BYTE_W-1:0] rdata_nxt;
    logic [WORD_W-1:0] out_word_r;
    logic [WORD_W-1:0] out_word_nxt;
    logic              out_full_r;
    logic              out_full_nxt;
    logic [WORD_W-1:0] in_word_r;
    logic [WORD_W-1:0] in_word_nxt;
    logic              in_full_r;
    logic              in_full_nxt;
    logic              obe_r;
    logic              obe_nxt;
    logic              ibf_r;
    logic              ibf_nxt;
    logic              start_rd;
    logic              start_wr;
    logic              rd_done;
    logic              wr_done;
    logic              completes;

    always_comb begin
        state_nxt    = state_r;
        stat_nxt     = stat_r;
        half_nxt     = half_r;
        rdata_nxt    = rdata_r;
        out_word_nxt = out_word_r;
        out_full_nxt = out_full_r;
        in_word_nxt  = in_word_r;
        in_full_nxt  = in_full_r;
        start_rd     = 1'b0;
        start_wr     = 1'b0;
        rd_done      = 1'b0;
        wr_done      = 1'b0;
        // in word mode only the high half completes the word
        completes    = !word_mode || half_r;
        if (single_strobe_mode) begin
            start_rd = rd_frame && dir_rd;
            start_wr = wr_frame && !dir_rd;
        end else begin
            start_rd = rd_frame && !wr_act;
            start_wr = wr_frame && !rd_act;
        end
        case (state_r)
            host_port_pkg::st_idle: begin
                if (start_rd) begin
                    state_nxt = host_port_pkg::st_read;
                    stat_nxt  = stat_s;
                    half_nxt  = half_s;
                    if (stat_s) begin
                        rdata_nxt = '0;
                        rdata_nxt[`STAT_OBE_BIT] = !out_full_r;
                        rdata_nxt[`STAT_IBF_BIT] = in_full_r;
                    end else begin
                        rdata_nxt = half_s ? out_word_r[WORD_W-1:BYTE_W]
                                           : out_word_r[BYTE_W-1:0];
                    end
                end else if (start_wr) begin
                    state_nxt = host_port_pkg::st_write;
                    stat_nxt  = stat_s;
                    half_nxt  = half_s;
                end
            end
            host_port_pkg::st_read: begin
                if (!rd_frame) begin
                    state_nxt = host_port_pkg::st_hold;
                    rd_done   = !stat_r;
                end
            end
            host_port_pkg::st_write: begin
                // strobe or select going inactive ends write, data taken
                if (!wr_frame) begin
                    state_nxt = host_port_pkg::st_idle;
                    wr_done   = !stat_r;
                    if (!stat_r) begin
                        if (half_r) begin
                            in_word_nxt[WORD_W-1:BYTE_W] = data_s;
                        end else begin
                            in_word_nxt[BYTE_W-1:0] = data_s;
                        end
                    end
                end
            end
            host_port_pkg::st_hold: begin
                state_nxt = host_port_pkg::st_idle;
            end
            default: begin
                state_nxt = host_port_pkg::st_idle;
            end
        endcase
        // read of the word empties output buffer
        if (rd_done && completes) begin
            out_full_nxt = 1'b0;
        end
        // load wins over a clearing read
        if (out_word_load) begin
            out_word_nxt = out_word;
            out_full_nxt = 1'b1;
        end
        if (in_word_take) begin
            in_full_nxt = 1'b0;
        end
        // write of the word fills input buffer
        if (wr_done && completes) begin
            in_full_nxt = 1'b1;
        end
        // inversion only on the pin level
        obe_nxt = !out_full_nxt ^ obe_invert;
        ibf_nxt = in_full_nxt ^ ibf_invert;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_r    <= host_port_pkg::st_idle;
            stat_r     <= 1'b0;
            half_r     <= 1'b0;
            rdata_r    <= `BYTE_RST;
            out_word_r <= `WORD_RST;
            out_full_r <= 1'b0;
            in_word_r  <= `WORD_RST;
            in_full_r  <= 1'b0;
            obe_r      <= `OBE_RST;
            ibf_r      <= `IBF_RST;
        end else begin
            state_r    <= state_nxt;
            stat_r     <= stat_nxt;
            half_r     <= half_nxt;
            rdata_r    <= rdata_nxt;
            out_word_r <= out_word_nxt;
            out_full_r <= out_full_nxt;
            in_word_r  <= in_word_nxt;
            in_full_r  <= in_full_nxt;
            obe_r      <= obe_nxt;
            ibf_r      <= ibf_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // drive during read plus one hold cycle
    assign host_byte_bus_oe      = state_r == host_port_pkg::st_read ||
                                   state_r == host_port_pkg::st_hold;
    assign host_byte_bus_out     = rdata_r;
    assign out_buffer_empty_flag = obe_r;
    assign in_buffer_full_flag   = ibf_r;
    assign out_word_pending      = out_full_r;
    assign in_word               = in_word_r;
    assign in_word_ready         = in_full_r;

    // ****************************************
    // assertions
    // ****************************************
    // synchroniser delay means pin timing holds only at slow host rates
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_read_begin;
        state_r == host_port_pkg::st_idle && start_rd;
    endsequence
    sequence s_read_end;
        state_r == host_port_pkg::st_read && !rd_frame;
    endsequence
    sequence s_write_end;
        state_r == host_port_pkg::st_write && !wr_frame && !stat_r;
    endsequence

    a_read_drive_start: assert property (
        s_read_begin ##0 (!stat_s && !out_word_load) |=> host_byte_bus_oe
            && state_r == host_port_pkg::st_read
            && host_byte_bus_out == ($past(half_s)
                ? out_word_r[WORD_W-1:BYTE_W] : out_word_r[BYTE_W-1:0]))
        else $error("read did not drive the bus");
    a_read_hold_one: assert property (
        s_read_end |=> host_byte_bus_oe ##1 !host_byte_bus_oe)
        else $error("read data hold is not one cycle");
    a_obe_after_read: assert property (
        s_read_end ##0 (!stat_r && completes && !out_word_load)
            |=> out_buffer_empty_flag == !obe_invert)
        else $error("empty flag missed a completed read");
    a_ibf_after_write: assert property (
        s_write_end ##0 (completes && !in_word_take)
            |=> in_buffer_full_flag == !ibf_invert && in_word_ready)
        else $error("full flag missed a completed write");
    a_write_capture: assert property (
        s_write_end ##0 half_r |=> in_word[WORD_W-1:BYTE_W] == $past(data_s))
        else $error("write data not captured at end");
    a_dir_no_frame: assert property (
        single_strobe_mode && state_r == host_port_pkg::st_read && rd_frame
            |=> state_r != host_port_pkg::st_idle)
        else $error("direction change framed a transaction");
    a_sep_read_start: assert property (
        !single_strobe_mode && state_r == host_port_pkg::st_idle
            && sel_act && rd_act && !wr_act
            |=> state_r == host_port_pkg::st_read)
        else $error("separate read did not start");
    a_strobe_level: assert property (
        single_strobe_mode && state_r == host_port_pkg::st_idle
            && sel_act && (pin_s[`PIN_DS] != data_strobe_active_high)
            |=> state_r == host_port_pkg::st_idle)
        else $error("inactive strobe level started a transaction");
    a_load_wins: assert property (
        out_word_load |=> out_word_pending ##0
            out_buffer_empty_flag == obe_invert)
        else $error("buffer load lost against a read");

endmodule // parallel_host_port

`default_nettype wire

// >>> verification/host_cpu_model.sv
`default_nettype none

module host_cpu_model (
    input  wire logic       mclk,
    input  wire logic       ds_high,
    input  wire logic [7:0] bus_out,
    input  wire logic       bus_oe,
    output var  logic       sel_n,
    output var  logic       rd_n,
    output var  logic       wr_n,
    output var  logic       ds,
    output var  logic       dir,
    output var  logic       stat,
    output var  logic       half,
    output var  logic [7:0] bus_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic drv;

    initial begin
        sel_n  = 1'b1;
        rd_n   = 1'b1;
        wr_n   = 1'b1;
        ds     = 1'b1;
        dir    = 1'b0;
        stat   = 1'b0;
        half   = 1'b0;
        bus_in = 8'h00;
        drv    = 1'b0;
    end

    // released bus keeps moving, never a stale value
    always @(negedge mclk) begin
        if (!drv) begin
            bus_in <= ~bus_in;
        end
    end

    // ****************************************
    // one host transfer
    // ****************************************
    // selects and direction set early
    task automatic xfer(input logic single, input logic rd, input logic st,
                        input logic hf, input logic [7:0] wd,
                        input logic wig, output logic [7:0] rdat,
                        output logic ok);
        int n;
        n = 0;
        ok = 1'b1;
        rdat = 8'h00;
        @(posedge mclk);
        ds     <= ~ds_high;
        stat   <= st;
        half   <= hf;
        dir    <= rd;
        drv    <= ~rd;
        bus_in <= wd;
        @(posedge mclk);
        sel_n <= 1'b0;
        repeat (5) @(posedge mclk);
        if (single) begin
            ds <= ds_high;
        end else if (rd) begin
            rd_n <= 1'b0;
        end else begin
            wr_n <= 1'b0;
        end
        if (rd) begin
            @(negedge mclk);
            while (bus_oe !== 1'b1 && n < 12) begin
                @(negedge mclk);
                n++;
            end
            ok = (bus_oe === 1'b1);
            repeat (2) @(negedge mclk);
            rdat = bus_out;
        end else begin
            repeat (8) @(posedge mclk);
        end
        @(posedge mclk);
        if (wig) begin
            dir <= ~rd;
            repeat (6) @(posedge mclk);
        end
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        ds   <= ~ds_high;
        repeat (6) @(posedge mclk);
        sel_n <= 1'b1;
        drv   <= 1'b0;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
    endtask
endmodule // host_cpu_model

`default_nettype wire

// >>> verification/test_parallel_host_port.sv
`default_nettype none

module test_parallel_host_port;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk;
    logic        rst_b;
    logic        sel_n;
    logic        rd_n;
    logic        wr_n;
    logic        ds;
    logic        dir;
    logic        stat;
    logic        half;
    logic [7:0]  bus_in;
    logic [7:0]  bus_out;
    logic        bus_oe;
    logic        obe_flag;
    logic        ibf_flag;
    logic        single_strobe_mode;
    logic        data_strobe_active_high;
    logic        word_mode;
    logic        obe_invert;
    logic        ibf_invert;
    logic [15:0] out_word;
    logic        out_word_load;
    logic        pending;
    logic [15:0] in_word;
    logic        ready;
    logic        in_word_take;
    logic [7:0]  r;
    logic        ok;
    int          n_errors;
    int          compares;
    int          cycles;

    host_cpu_model host (
        .mclk(mclk), .ds_high(data_strobe_active_high), .bus_out(bus_out),
        .bus_oe(bus_oe), .sel_n(sel_n), .rd_n(rd_n), .wr_n(wr_n), .ds(ds),
        .dir(dir), .stat(stat), .half(half), .bus_in(bus_in)
    );

    parallel_host_port dut (
        .mclk(mclk), .rst_b(rst_b), .host_select_n(sel_n),
        .host_read_strobe_n(rd_n), .host_write_strobe_n(wr_n),
        .host_data_strobe(ds), .host_direction_line(dir),
        .status_select(stat), .byte_half_select(half),
        .host_byte_bus_in(bus_in), .host_byte_bus_out(bus_out),
        .host_byte_bus_oe(bus_oe), .out_buffer_empty_flag(obe_flag),
        .in_buffer_full_flag(ibf_flag),
        .single_strobe_mode(single_strobe_mode),
        .data_strobe_active_high(data_strobe_active_high),
        .word_mode(word_mode), .obe_invert(obe_invert),
        .ibf_invert(ibf_invert), .out_word(out_word),
        .out_word_load(out_word_load), .out_word_pending(pending),
        .in_word(in_word), .in_word_ready(ready),
        .in_word_take(in_word_take)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic end_of_test();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic load(input logic [15:0] w);
        @(posedge mclk);
        out_word      <= w;
        out_word_load <= 1'b1;
        @(posedge mclk);
        out_word_load <= 1'b0;
        repeat (2) @(negedge mclk);
    endtask

    task automatic take();
        @(posedge mclk);
        in_word_take <= 1'b1;
        @(posedge mclk);
        in_word_take <= 1'b0;
        repeat (2) @(negedge mclk);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_word_read();
        word_mode <= 1'b1;
        load(16'ha55a);
        chk({15'h0, obe_flag}, 16'h0, "empty flag after load");
        host.xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 1'b0, r, ok);
        chk({15'h0, ok}, 16'h1, "read answered");
        chk({8'h0, r}, 16'h005a, "low byte read");
        chk({15'h0, obe_flag}, 16'h0, "low half keeps full");
        host.xfer(1'b0, 1'b1, 1'b0, 1'b1, 8'h00, 1'b0, r, ok);
        chk({8'h0, r}, 16'h00a5, "high byte read");
        chk({15'h0, obe_flag}, 16'h1, "empty after word");
    endtask

    task automatic t_word_write();
        host.xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'h3c, 1'b0, r, ok);
        chk({15'h0, ibf_flag}, 16'h0, "low half no full");
        host.xfer(1'b0, 1'b0, 1'b0, 1'b1, 8'hc3, 1'b0, r, ok);
        chk(in_word, 16'hc33c, "word written");
        chk({15'h0, ibf_flag}, 16'h1, "full after word");
        chk({15'h0, ready}, 16'h1, "ready after word");
        take();
        chk({15'h0, ibf_flag}, 16'h0, "full cleared");
        chk({15'h0, ready}, 16'h0, "ready cleared");
    endtask

    task automatic t_single();
        for (int lvl = 0; lvl < 2; lvl++) begin
            @(posedge mclk);
            single_strobe_mode      <= 1'b1;
            data_strobe_active_high <= lvl[0];
            word_mode               <= 1'b0;
            host.xfer(1'b1, 1'b0, 1'b0, 1'b1, 8'h69 ^ lvl[7:0], 1'b1, r,
                      ok);
            chk({8'h0, in_word[15:8]}, 16'h0069 ^ lvl[15:0], "ds wr");
            chk({15'h0, ibf_flag}, 16'h1, "ds write full");
            take();
            load(16'h00e1 ^ lvl[15:0]);
            host.xfer(1'b1, 1'b1, 1'b0, 1'b0, 8'h00, 1'b0, r, ok);
            chk({15'h0, ok}, 16'h1, "ds read answered");
            chk({8'h0, r}, 16'h00e1 ^ lvl[15:0], "ds read");
            chk({15'h0, obe_flag}, 16'h1, "ds read empty");
        end
    endtask

    task automatic t_invert();
        @(posedge mclk);
        obe_invert <= 1'b1;
        ibf_invert <= 1'b1;
        repeat (3) @(negedge mclk);
        chk({14'h0, obe_flag, ibf_flag}, 16'h1, "inverted idle");
        load(16'h4400);
        chk({15'h0, obe_flag}, 16'h1, "inverted full");
        host.xfer(1'b1, 1'b1, 1'b0, 1'b1, 8'h00, 1'b0, r, ok);
        chk({15'h0, obe_flag}, 16'h0, "inverted empty");
        @(posedge mclk);
        obe_invert <= 1'b0;
        ibf_invert <= 1'b0;
    endtask

    task automatic t_status();
        host.xfer(1'b1, 1'b0, 1'b1, 1'b0, 8'h55, 1'b0, r, ok);
        chk({15'h0, ready}, 16'h0, "status write ignored");
        load(16'h1234);
        host.xfer(1'b1, 1'b1, 1'b1, 1'b0, 8'h00, 1'b0, r, ok);
        chk({8'h0, r}, 16'h0000, "status full out");
        host.xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h77, 1'b0, r, ok);
        host.xfer(1'b1, 1'b1, 1'b1, 1'b1, 8'h00, 1'b0, r, ok);
        chk({8'h0, r}, 16'h0002, "status full in");
        chk({8'h0, in_word[7:0]}, 16'h0077, "byte write");
        take();
    endtask

    task automatic t_mode();
        @(posedge mclk);
        single_strobe_mode <= 1'b0;
        host.xfer(1'b1, 1'b1, 1'b0, 1'b0, 8'h00, 1'b0, r, ok);
        chk({15'h0, ok}, 16'h0, "ds ignored separate");
        @(posedge mclk);
        single_strobe_mode <= 1'b1;
        host.xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 1'b0, r, ok);
        chk({15'h0, ok}, 16'h0, "rd ignored single");
        chk({15'h0, pending}, 16'h1, "still pending");
    endtask

    // ****************************************
    // main sequence and timeout
    // ****************************************
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            $display("[FAIL] %0t timeout", $time);
            end_of_test();
        end
    end

    initial begin
        n_errors = 0;
        compares = 0;
        cycles = 0;
        rst_b = 1'b0;
        single_strobe_mode = 1'b0;
        data_strobe_active_high = 1'b0;
        word_mode = 1'b1;
        obe_invert = 1'b1;
        ibf_invert = 1'b1;
        out_word = 16'h0000;
        out_word_load = 1'b0;
        in_word_take = 1'b0;
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        chk({14'h0, obe_flag, ibf_flag}, 16'h2, "reset flags");
        @(posedge mclk);
        obe_invert <= 1'b0;
        ibf_invert <= 1'b0;
        rst_b      <= 1'b1;
        repeat (2) @(negedge mclk);
        chk({14'h0, obe_flag, ibf_flag}, 16'h2, "released flags");
        repeat (2) @(posedge mclk);
        t_word_read();
        t_word_write();
        t_single();
        t_invert();
        t_status();
        t_mode();
        end_of_test();
    end
endmodule // test_parallel_host_port

`default_nettype wire
